/* logic/adc_readout_pkg.sv */
// Package of constants for the isolated converter sample readout block
package adc_readout_pkg;

    // ========================================================================
    // Timing
    localparam int unsigned CORE_CLK_HZ      = 50_000_000;
    localparam int unsigned CONVERTER_CLOCK_IN_HZ         = 8_192_000;
    // Phase step per core cycle in kHz units keeps the accumulator narrow
    localparam int unsigned CONVERTER_CLOCK_IN_STEP       = CONVERTER_CLOCK_IN_HZ / 1000;
    localparam int unsigned CONVERTER_CLOCK_IN_MODULUS    = CORE_CLK_HZ / 1000;
    localparam int unsigned MOD_CLK_DIV      = 2;
    localparam int unsigned OSR_DEFAULT      = 1024;
    localparam int unsigned SAMPLE_RATE_SPS  = CONVERTER_CLOCK_IN_HZ / (MOD_CLK_DIV * OSR_DEFAULT);

    // ========================================================================
    // Frame layout
    localparam int unsigned WORD_BITS        = 24;
    localparam int unsigned FRAME_WORDS      = 4;
    localparam int unsigned FRAME_BYTES      = 12;
    localparam int unsigned FRAME_BITS       = FRAME_BYTES * 8;
    localparam int unsigned CRC_BITS         = 16;
    localparam logic [15:0] CRC_POLY         = 16'h1021;
    localparam logic [15:0] CRC_INIT         = 16'hFFFF;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] REG_CTRL          = 8'h00;
    localparam logic [7:0] REG_GAIN          = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS    = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK      = 8'h0C;
    localparam logic [7:0] REG_LAST_CH0      = 8'h10;
    localparam logic [7:0] REG_LAST_CH1      = 8'h14;
    localparam logic [7:0] REG_FRAME_COUNT   = 8'h18;

    // ========================================================================
    // Fields and reset values
    localparam int unsigned CTRL_ENABLE_BIT  = 0;
    localparam int unsigned GAIN_CH0_LSB     = 0;
    localparam int unsigned GAIN_CH1_LSB     = 4;
    localparam int unsigned GAIN_FIELD_BITS  = 3;
    localparam int unsigned IRQ_BITS         = 3;
    localparam int unsigned IRQ_SAMPLE_BIT   = 0;
    localparam int unsigned IRQ_FRAME_BIT    = 1;
    localparam int unsigned IRQ_OVERRUN_BIT  = 2;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
    // Gain codes: 0 selects x1, 4 selects x16
    localparam logic [2:0]  GAIN_CH0_RESET   = 3'h0;
    localparam logic [2:0]  GAIN_CH1_RESET   = 3'h4;
    localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;

endpackage

/* logic/isolated_adc_sample_readout.sv */
// Converter-side sample generation, ready signalling and 12-byte serial frame readout
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: The host acts as four-wire serial controller with select, clock, data out and data in.
// RULE_02: The host masks its sample interrupts, pulses restart, then unmasks and configures.
// RULE_03: Every frame uses 24-bit words and a 16-bit CCITT CRC that both ends agree on.
// RULE_04: The ready output stays high while no result is available and goes low once results are ready.
// RULE_05: The host programs gain 1 on the voltage channel and gain 16 on the current channel.
// RULE_06: The host routes both channels to the external pins with zero phase delay.
// RULE_07: The host programs an oversampling ratio of 1024, all channels on, high-resolution mode.
// RULE_08: The host starts one frame readout on every falling edge of the ready line.
// RULE_09: The modulator clock is the converter clock divided by two, one sample per ratio cycles.
// RULE_10: An 8.192MHz converter clock with ratio 1024 gives 4000 samples per second per channel.
// RULE_11: The host shifts out zero bytes while it captures the frame.
// RULE_12: A frame is 12 bytes long and its end is signalled for the CRC check.
// RULE_13: The host splits the frame into voltage and current only after the CRC passes.
// RULE_14: The host takes channel 0 as line voltage and channel 1 as shunt current.
// RULE_15: The frame is status, channel 0, channel 1 and CRC words, two's-complement, MSB first.
// RULE_16: The host discards a frame with a bad CRC and raises a sticky CRC error flag.
module isolated_adc_sample_readout #(
    parameter int unsigned OVERSAMPLING_RATIO      = adc_readout_pkg::OSR_DEFAULT,
    parameter int unsigned CLK_STEP = adc_readout_pkg::CONVERTER_CLOCK_IN_STEP,
    parameter int unsigned CLK_MOD  = adc_readout_pkg::CONVERTER_CLOCK_IN_MODULUS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output logic      [31:0] regRdData,
    output logic             irq,
    // Analog front end results
    input  wire logic [23:0] voltageSample,
    input  wire logic [23:0] currentSample,
    // Serial link and ready line
    input  wire logic        spiCsN,
    input  wire logic        spiSclk,
    input  wire logic        spiMosi,
    output logic             spiMiso,
    output logic             spiMisoEn,
    output logic             sample_ready_n
);
    import adc_readout_pkg::*;

    // ========================================================================
    // Parameter checks
    // Counters are 16 bits wide; the default modulus must still fit
    if (OVERSAMPLING_RATIO < 2 || OVERSAMPLING_RATIO > 65536 || CLK_STEP == 0 || CLK_STEP > CLK_MOD || CLK_MOD > 65535) begin : g_bad_param
        $error("isolated_adc_sample_readout: unsupported parameter values");
    end

    localparam logic [15:0] STEP_W = 16'(CLK_STEP);
    localparam logic [15:0] MOD_W  = 16'(CLK_MOD);
    localparam logic [15:0] OSR_LAST = 16'(OVERSAMPLING_RATIO - 1);
    localparam logic [6:0]  FRAME_LAST = 7'(FRAME_BITS - 1);

    // CCITT CRC over the first three words, MSB first
    function automatic logic [15:0] crc_ccitt(input logic [71:0] data);
        logic [15:0] crc;
        logic        fb;
        crc = CRC_INIT;
        for (int i = 71; i >= 0; i--) begin
            fb = crc[15] ^ data[i];
            crc = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return crc;
    endfunction

    // ========================================================================
    // State
    logic [15:0] phaseAcc_q, phaseAcc_d;
    logic        modDiv_q, modDiv_d;
    logic [15:0] osrCnt_q, osrCnt_d;
    logic        ctrlEn_q, ctrlEn_d;
    logic [2:0]  gain0_q, gain0_d;
    logic [2:0]  amplifier_gain_cfg_q, amplifier_gain_cfg_d;
    logic [IRQ_BITS-1:0] irqStat_q, irqStat_d;
    logic [IRQ_BITS-1:0] irqMask_q, irqMask_d;
    logic [23:0] lastCh0_q, lastCh0_d;
    logic [23:0] lastCh1_q, lastCh1_d;
    logic [31:0] frameCnt_q, frameCnt_d;
    logic        readyN_q, readyN_d;
    logic        overrun_q, overrun_d;
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic [6:0]  bitCnt_q, bitCnt_d;
    logic        active_q, active_d;
    logic        sclk_q, sclk_d;
    logic        csN_q, csN_d;
    logic        miso_q, miso_d;
    logic [31:0] rdData_q, rdData_d;

    logic        clkinTick;
    logic        modTick;
    logic        sampleTick;
    logic        csFall;
    logic        sclkRise;
    logic        sclkFall;
    logic [16:0] accSum;
    logic [71:0] crcData;
    logic [IRQ_BITS-1:0] events;

    // ========================================================================
    // Next-state logic
    always_comb begin
        phaseAcc_d = phaseAcc_q;
        modDiv_d   = modDiv_q;
        osrCnt_d   = osrCnt_q;
        ctrlEn_d   = ctrlEn_q;
        gain0_d    = gain0_q;
        amplifier_gain_cfg_d    = amplifier_gain_cfg_q;
        irqMask_d  = irqMask_q;
        lastCh0_d  = lastCh0_q;
        lastCh1_d  = lastCh1_q;
        frameCnt_d = frameCnt_q;
        readyN_d   = readyN_q;
        overrun_d  = overrun_q;
        shift_d    = shift_q;
        bitCnt_d   = bitCnt_q;
        active_d   = active_q;
        miso_d     = miso_q;
        rdData_d   = 32'h0000_0000;
        sclk_d     = spiSclk;
        csN_d      = spiCsN;
        events     = '0;

        // Fractional divider stands in for the 8.192MHz converter clock
        accSum    = {1'b0, phaseAcc_q} + {1'b0, STEP_W};
        clkinTick = accSum >= {1'b0, MOD_W};
        phaseAcc_d = clkinTick ? 16'(accSum - {1'b0, MOD_W}) : accSum[15:0]; // RULE_10
        modTick    = clkinTick && modDiv_q; // RULE_09
        if (clkinTick) begin
            modDiv_d = ~modDiv_q; // RULE_09
        end
        sampleTick = modTick && (osrCnt_q == OSR_LAST) && ctrlEn_q;
        if (modTick) begin
            osrCnt_d = (osrCnt_q == OSR_LAST) ? 16'h0000 : 16'(osrCnt_q + 16'h0001); // RULE_09
        end

        csFall   = csN_q && !spiCsN;
        sclkRise = spiSclk && !sclk_q;
        sclkFall = !spiSclk && sclk_q;

        // Status, voltage, current, CRC; CRC sits in the top of the last word
        crcData = {overrun_q, 7'h00, 1'b0, amplifier_gain_cfg_q, 1'b0, gain0_q, 8'h00, lastCh0_q, lastCh1_q};

        // New results: latch both channels and pull the ready line low
        if (sampleTick) begin
            lastCh0_d = voltageSample;
            lastCh1_d = currentSample;
            readyN_d  = 1'b0; // RULE_04
            events[IRQ_SAMPLE_BIT] = 1'b1;
            // A result never read out is lost; flag it in the next status word
            if (!readyN_q || active_q) begin
                overrun_d = 1'b1;
                events[IRQ_OVERRUN_BIT] = 1'b1;
            end
        end

        // Frame start loads all four words and releases the ready line, unless a new sample lands in the same cycle
        if (csFall) begin
            shift_d  = {crcData, crc_ccitt(crcData), 8'h00}; // RULE_03 RULE_15
            miso_d   = crcData[71]; // RULE_15
            bitCnt_d = 7'h00;
            active_d = 1'b1;
            if (!sampleTick) begin
                readyN_d  = 1'b1; // RULE_04
                overrun_d = 1'b0;
            end
        end else if (active_q && spiCsN) begin
            // Select released early: frame abandoned, data stays read
            active_d = 1'b0;
        end else if (active_q) begin
            if (sclkRise && bitCnt_q != 7'h00) begin
                miso_d = shift_q[FRAME_BITS-1];
            end
            if (sclkFall) begin
                shift_d  = {shift_q[FRAME_BITS-2:0], spiMosi};
                bitCnt_d = 7'(bitCnt_q + 7'h01);
                if (bitCnt_q == FRAME_LAST) begin
                    active_d = 1'b0; // RULE_12
                    frameCnt_d = 32'(frameCnt_q + 32'h0000_0001);
                    events[IRQ_FRAME_BIT] = 1'b1; // RULE_12
                end
            end
        end

        // Register writes
        if (regWrStrobe) begin
            unique case (regAddr)
                REG_CTRL:     ctrlEn_d = regWrData[CTRL_ENABLE_BIT];
                REG_GAIN: begin
                    gain0_d = regWrData[GAIN_CH0_LSB +: GAIN_FIELD_BITS];
                    amplifier_gain_cfg_d = regWrData[GAIN_CH1_LSB +: GAIN_FIELD_BITS];
                end
                REG_IRQ_MASK: irqMask_d = regWrData[IRQ_BITS-1:0];
                default:      ;
            endcase
        end

        // Register reads; unmapped addresses return zero
        if (regRdStrobe) begin
            unique case (regAddr)
                REG_CTRL:        rdData_d = {31'h0, ctrlEn_q};
                REG_GAIN:        rdData_d = {25'h0, amplifier_gain_cfg_q, 1'b0, gain0_q};
                REG_IRQ_STATUS:  rdData_d = {29'h0, irqStat_q};
                REG_IRQ_MASK:    rdData_d = {29'h0, irqMask_q};
                REG_LAST_CH0:    rdData_d = {{8{lastCh0_q[23]}}, lastCh0_q};
                REG_LAST_CH1:    rdData_d = {{8{lastCh1_q[23]}}, lastCh1_q};
                REG_FRAME_COUNT: rdData_d = frameCnt_q;
                default:         rdData_d = 32'h0000_0000;
            endcase
        end

        // Read clears status, but an event in the same cycle survives
        if (regRdStrobe && regAddr == REG_IRQ_STATUS) begin
            irqStat_d = events;
        end else begin
            irqStat_d = irqStat_q | events;
        end
    end

    // ========================================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phaseAcc_q <= 16'h0000;
            modDiv_q   <= 1'b0;
            osrCnt_q   <= 16'h0000;
            ctrlEn_q   <= CTRL_RESET[CTRL_ENABLE_BIT];
            gain0_q    <= GAIN_CH0_RESET;
            amplifier_gain_cfg_q    <= GAIN_CH1_RESET;
            irqStat_q  <= '0;
            irqMask_q  <= IRQ_MASK_RESET;
            lastCh0_q  <= 24'h000000;
            lastCh1_q  <= 24'h000000;
            frameCnt_q <= 32'h0000_0000;
            readyN_q   <= 1'b1;
            overrun_q  <= 1'b0;
            shift_q    <= '0;
            bitCnt_q   <= 7'h00;
            active_q   <= 1'b0;
            sclk_q     <= 1'b0;
            csN_q      <= 1'b1;
            miso_q     <= 1'b0;
            rdData_q   <= 32'h0000_0000;
        end else begin
            phaseAcc_q <= phaseAcc_d;
            modDiv_q   <= modDiv_d;
            osrCnt_q   <= osrCnt_d;
            ctrlEn_q   <= ctrlEn_d;
            gain0_q    <= gain0_d;
            amplifier_gain_cfg_q    <= amplifier_gain_cfg_d;
            irqStat_q  <= irqStat_d;
            irqMask_q  <= irqMask_d;
            lastCh0_q  <= lastCh0_d;
            lastCh1_q  <= lastCh1_d;
            frameCnt_q <= frameCnt_d;
            readyN_q   <= readyN_d;
            overrun_q  <= overrun_d;
            shift_q    <= shift_d;
            bitCnt_q   <= bitCnt_d;
            active_q   <= active_d;
            sclk_q     <= sclk_d;
            csN_q      <= csN_d;
            miso_q     <= miso_d;
            rdData_q   <= rdData_d;
        end
    end

    // ========================================================================
    // Outputs
    assign regRdData      = rdData_q;
    assign irq            = |(irqStat_q & irqMask_q);
    assign sample_ready_n = readyN_q; // RULE_04
    assign spiMiso        = miso_q;
    assign spiMisoEn      = !spiCsN;

endmodule

`default_nettype wire

/* verif/isolated_adc_sample_readout_chk.sv */
// Port assertions for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module isolated_adc_sample_readout_chk #(
    parameter int unsigned OVERSAMPLING_RATIO      = adc_readout_pkg::OSR_DEFAULT,
    parameter int unsigned CLK_STEP = adc_readout_pkg::CONVERTER_CLOCK_IN_STEP,
    parameter int unsigned CLK_MOD  = adc_readout_pkg::CONVERTER_CLOCK_IN_MODULUS
) (
    // Clock, reset and register port
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrStrobe,
    input wire logic        regRdStrobe,
    input wire logic [31:0] regRdData,
    input wire logic        irq,
    // Samples and serial link
    input wire logic [23:0] voltageSample,
    input wire logic [23:0] currentSample,
    input wire logic        spiCsN,
    input wire logic        spiSclk,
    input wire logic        spiMosi,
    input wire logic        spiMiso,
    input wire logic        spiMisoEn,
    input wire logic        sample_ready_n
);
    import adc_readout_pkg::*;
    // ========================================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_frameStart; $fell(spiCsN); endsequence
    sequence s_readyUp; sample_ready_n; endsequence
    property p_readyRet; s_frameStart |=> s_readyUp; endproperty
    a_readyRet: assert property (p_readyRet) else $error("ready kept low");
    property p_readyHold; !sample_ready_n && spiCsN |=> !sample_ready_n; endproperty
    a_readyHold: assert property (p_readyHold) else $error("ready lost");
    property p_misoEn; spiMisoEn == !spiCsN; endproperty
    a_misoEn: assert property (p_misoEn) else $error("data enable wrong");
    // Data may only move after a rising clock or a falling select, never while the clock rests low
    property p_misoStable;
        !spiCsN && !$past(spiCsN, 3) && !spiSclk && !$past(spiSclk) |-> $stable(spiMiso);
    endproperty
    a_misoStable: assert property (p_misoStable) else $error("data moved");
    property p_rdIdle; !$past(regRdStrobe) |-> regRdData == 32'h0; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
    property p_unmapped; regRdStrobe && regAddr > REG_FRAME_COUNT |=> regRdData == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_statusWidth; regRdStrobe && regAddr == REG_IRQ_STATUS |=> regRdData[31:3] == 29'h0;
    endproperty
    a_statusWidth: assert property (p_statusWidth) else $error("status too wide");
    property p_lastSign;
        regRdStrobe && regAddr == REG_LAST_CH0 |=> regRdData[31:24] == {8{regRdData[23]}};
    endproperty
    a_lastSign: assert property (p_lastSign) else $error("sample not sign extended");
endmodule
`default_nettype wire

/* verif/adc_host_model.sv */
// Host serial controller model that reads converter frames
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
    // Clock and control
    input  wire logic   core_clk,
    input  wire logic   autoRead,
    input  wire logic   go,
    // Converter side
    input  wire logic   spiMiso,
    input  wire logic   spiMisoEn,
    input  wire logic   sample_ready_n,
    output logic        spiCsN,
    output logic        spiSclk,
    output logic        spiMosi,
    // Captured frame
    output logic        done,
    output logic [95:0] frame
);
    import adc_readout_pkg::*;
    logic readyQ;
    logic misoLine;
    // A released line must not look like valid data, so it reads inverted
    assign misoLine = spiMisoEn ? spiMiso : ~frame[0];
    // ========================================================================
    // Frame engine
    initial begin
        {spiCsN, spiSclk, spiMosi, done, readyQ} = 5'b10001;
        frame = '0;
        forever begin
            @(posedge core_clk);
            readyQ <= sample_ready_n;
            done   <= 1'b0;
            if (go || (autoRead && readyQ && !sample_ready_n)) begin
                spiCsN <= 1'b0;
                repeat (3) @(posedge core_clk);
                // Three cycles a level leave the converter time to settle its bit
                for (int i = 0; i < FRAME_BITS; i++) begin
                    spiSclk <= 1'b1;
                    repeat (3) @(posedge core_clk);
                    spiSclk <= 1'b0;
                    frame   <= {frame[94:0], misoLine};
                    repeat (3) @(posedge core_clk);
                end
                spiCsN <= 1'b1;
                done   <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/isolated_adc_sample_readout_tb_top.sv */
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module isolated_adc_sample_readout_tb_top;
    import adc_readout_pkg::*;
    // Short ratio gives a 1024-cycle sample period
    localparam int unsigned SIM_OSR = 512;
    logic        core_clk, rst, regWrStrobe, regRdStrobe, irq, autoRead, go, done;
    logic        spiCsN, spiSclk, spiMosi, spiMiso, spiMisoEn, sample_ready_n;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData;
    logic [23:0] voltageSample, currentSample;
    logic [95:0] frame;
    int          num_errors = 0, compares = 0, cyc = 0;
    time         t0;
    logic        crcErr = 1'b0;
    logic [7:0]  rAddr [6] = '{REG_CTRL, REG_GAIN, REG_IRQ_STATUS, REG_IRQ_MASK, 8'h18, 8'h1C};
    logic [31:0] rVal [6] = '{CTRL_RESET, 32'h0000_0040, 32'h0, 32'h0, 32'h0, 32'h0};
    // ========================================================================
    // Design and host
    isolated_adc_sample_readout #(.OVERSAMPLING_RATIO(SIM_OSR), .CLK_STEP(1), .CLK_MOD(1))
        i_isolated_adc_sample_readout (.core_clk, .rst, .regAddr, .regWrData, .regWrStrobe,
        .regRdStrobe, .regRdData, .irq, .voltageSample, .currentSample, .spiCsN, .spiSclk,
        .spiMosi, .spiMiso, .spiMisoEn, .sample_ready_n);
    adc_host_model i_adc_host_model (.core_clk, .autoRead, .go, .spiMiso, .spiMisoEn,
        .sample_ready_n, .spiCsN, .spiSclk, .spiMosi, .done, .frame);
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {regAddr, regWrData, regWrStrobe} <= {a, d, 1'b1};
        @(posedge core_clk);
        regWrStrobe <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        {regAddr, regRdStrobe} <= {a, 1'b1};
        @(posedge core_clk);
        regRdStrobe <= 1'b0;
        @(posedge core_clk);
        chk(regRdData, exp);
    endtask
    function automatic logic [15:0] crc16(input logic [71:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int k = 71; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    task automatic frameChk(input logic [23:0] w0);
        // A frame whose own CRC disagrees stays flagged for the rest of the run
        if (frame[23:8] !== crc16(frame[95:24])) crcErr = 1'b1;
        chk({31'h0, crcErr}, 32'h0);
        chk({8'h0, frame[95:72]}, {8'h0, w0});
        chk({8'h0, frame[71:48]}, {8'h0, voltageSample});
        chk({8'h0, frame[47:24]}, {8'h0, currentSample});
        chk({8'h0, frame[23:0]}, {8'h0, crc16({w0, voltageSample, currentSample}), 8'h00});
    endtask
    task automatic print_verdict();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ========================================================================
    // Tests
    initial begin
        core_clk = 1'b0;
        {rst, regWrStrobe, regRdStrobe, autoRead, go} = 5'b10000;
        {regAddr, regWrData} = '0;
        {voltageSample, currentSample} = {24'h80_0001, 24'h12_3456};
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) rdChk(rAddr[k], rVal[k]);
        $display("test reset values done");
        wr(REG_GAIN, 32'h0000_0040);
        wr(REG_IRQ_MASK, 32'h7);
        autoRead <= 1'b1;
        @(negedge sample_ready_n);
        t0 = $time;
        @(negedge sample_ready_n);
        chk(32'(($time - t0) / 20), 32'(2 * SIM_OSR));
        @(posedge core_clk iff done);
        autoRead <= 1'b0;
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, sample_ready_n}, 32'h1);
        wr(REG_CTRL, 32'h0);
        frameChk(24'h00_4000);
        rdChk(REG_IRQ_STATUS, 32'h3);
        rdChk(REG_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdChk(REG_LAST_CH0, 32'hFF80_0001);
        rdChk(REG_LAST_CH1, 32'h0012_3456);
        rdChk(REG_FRAME_COUNT, 32'h2);
        wr(REG_LAST_CH0, 32'h0);
        rdChk(REG_LAST_CH0, 32'hFF80_0001);
        $display("test frame readout done");
        // New input values prove that the next frame carries freshly latched samples
        {voltageSample, currentSample} <= {24'h7F_FFFE, 24'hFE_DCBA};
        wr(REG_GAIN, 32'h13);
        wr(REG_IRQ_MASK, 32'h4);
        wr(REG_CTRL, 32'h1);
        @(negedge sample_ready_n);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge core_clk iff irq);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk iff done);
        wr(REG_CTRL, 32'h0);
        frameChk(24'h80_1300);
        rdChk(REG_IRQ_STATUS, 32'h7);
        rdChk(REG_LAST_CH1, 32'hFFFE_DCBA);
        $display("test overrun done");
        print_verdict();
    end
endmodule
bind isolated_adc_sample_readout isolated_adc_sample_readout_chk #(.OVERSAMPLING_RATIO(OVERSAMPLING_RATIO),
    .CLK_STEP(CLK_STEP), .CLK_MOD(CLK_MOD)) i_isolated_adc_sample_readout_chk (.core_clk, .rst,
    .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .irq, .voltageSample,
    .currentSample, .spiCsN, .spiSclk, .spiMosi, .spiMiso, .spiMisoEn, .sample_ready_n);
`default_nettype wire
